/* File: include/hvip_consts.vh */
`ifndef HVIP_CONSTS_VH
`define HVIP_CONSTS_VH

// Register byte offsets on the Avalon-MM slave (word aligned).
`define HVIP_OFS_PIN_EN      6'h00
`define HVIP_OFS_PIN_FLAG    6'h04
`define HVIP_OFS_PIN_POL     6'h08
`define HVIP_OFS_HV_CFG      6'h0c
`define HVIP_OFS_HV_EVT      6'h10
`define HVIP_OFS_HV_FLAG     6'h14
`define HVIP_OFS_LEVELS      6'h18
`define HVIP_OFS_OC_EN       6'h1c
`define HVIP_OFS_OC_FLAG     6'h20
`define HVIP_OFS_ROUTE       6'h24

// Field positions in the high-voltage configuration register (two bits each).
`define HVIP_CFG_DIEN_LSB    0
`define HVIP_CFG_AEN_LSB     2
`define HVIP_CFG_RATIO_LSB   4
`define HVIP_CFG_DIR_LSB     6
`define HVIP_CFG_BYP_LSB     8
`define HVIP_CFG_OVR_LSB     10

// Field positions in the high-voltage event register.
`define HVIP_EVT_EN_LSB      0
`define HVIP_EVT_POL_LSB     2

// Field position of the port pin levels in the level register.
`define HVIP_LVL_PIN_LSB     8

// Reset values.
`define HVIP_RST_BYTE        8'h00
`define HVIP_RST_HV2         2'h0
`define HVIP_RST_CFG         12'h000
`define HVIP_RST_ROUTE       2'h0
`define HVIP_RST_DATA        32'h0000_0000

// Capture route field codes.
`define HVIP_ROUTE_SERIAL0   2'h0
`define HVIP_ROUTE_SERIAL1   2'h2

// ADC channel select codes of the internal high-voltage channels.
`define HVIP_ADC_CH_HV0      6'h0d
`define HVIP_ADC_CH_HV1      6'h0e

`endif

/* File: rtl/hvip_port.v */
`timescale 1ns/1ps
`include "hvip_consts.vh"

module hvip_port #(
    parameter PIN_W  = 8,
    parameter PIN_IMPL = 8'hff,
    parameter OC_W   = 5
) (
    input  wire              CLK,
    input  wire              RST,
    input  wire [5:0]        AVS_ADDRESS,
    input  wire              AVS_READ,
    input  wire              AVS_WRITE,
    input  wire [31:0]       AVS_WRITEDATA,
    input  wire [3:0]        AVS_BYTEENABLE,
    output reg  [31:0]       AVS_READDATA,
    output wire              AVS_WAITREQUEST,
    input  wire [PIN_W-1:0]  PIN_IN,
    input  wire [1:0]        HV_PIN_IN,
    input  wire              STOP_MODE,
    input  wire              REDUCED_PERF,
    input  wire [OC_W-1:0]   OC_DETECT,
    input  wire [OC_W-1:0]   OC_FULL_DRIVE,
    input  wire [OC_W-1:0]   OC_OUT_HIGH,
    input  wire [5:0]        ADC_ADC_CHANNEL_SELECT,
    input  wire              RXD0_IN,
    input  wire              RXD1_IN,
    input  wire              TIM_IC3_PIN,
    output reg               PIN_IRQ,
    output reg               HV_IRQ,
    output reg               OC_IRQ,
    output reg               WAKEUP,
    output reg  [1:0]        HV_DIG_BUF_EN,
    output reg  [1:0]        HV_ANA_EN,
    output reg  [1:0]        HV_RATIO_SEL,
    output reg  [1:0]        HV_DIRECT,
    output reg  [1:0]        HV_IMP_BYPASS,
    output reg  [1:0]        ADC_HV_CONNECT,
    output reg  [OC_W-1:0]   OC_MON_PWR,
    output reg  [OC_W-1:0]   OC_FORCE_LOW,
    output reg               TIM_IC3_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    reg  [PIN_W-1:0] pin_s1_q;
    reg  [PIN_W-1:0] pin_s2_q;
    reg  [PIN_W-1:0] pin_prev_q;
    reg  [1:0]       hv_s1_q;
    reg  [1:0]       hv_s2_q;
    reg  [1:0]       hv_prev_q;
    reg  [OC_W-1:0]  oc_s1_q;
    reg  [OC_W-1:0]  oc_s2_q;
    reg              rx0_s1_q;
    reg              rx0_s2_q;
    reg              rx1_s1_q;
    reg              rx1_s2_q;
    reg              ic3_s1_q;
    reg              ic3_s2_q;

    // First stages feed only the second stages, so metastability stays contained.
    always @(posedge CLK) begin
        if (RST) begin
            pin_s1_q <= {PIN_W{1'b0}};
            pin_s2_q <= {PIN_W{1'b0}};
            hv_s1_q  <= `HVIP_RST_HV2;
            hv_s2_q  <= `HVIP_RST_HV2;
            oc_s1_q  <= {OC_W{1'b0}};
            oc_s2_q  <= {OC_W{1'b0}};
            rx0_s1_q <= 1'b1;
            rx0_s2_q <= 1'b1;
            rx1_s1_q <= 1'b1;
            rx1_s2_q <= 1'b1;
            ic3_s1_q <= 1'b0;
            ic3_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
            hv_s1_q  <= HV_PIN_IN;
            hv_s2_q  <= hv_s1_q;
            oc_s1_q  <= OC_DETECT;
            oc_s2_q  <= oc_s1_q;
            rx0_s1_q <= RXD0_IN;
            rx0_s2_q <= rx0_s1_q;
            rx1_s1_q <= RXD1_IN;
            rx1_s2_q <= rx1_s1_q;
            ic3_s1_q <= TIM_IC3_PIN;
            ic3_s2_q <= ic3_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and bus decode.

    reg  [PIN_W-1:0] pin_en_q;
    reg  [PIN_W-1:0] pin_flag_q;
    reg  [PIN_W-1:0] pin_flag_d;
    reg  [PIN_W-1:0] pin_pol_q;
    reg  [11:0]      hv_cfg_q;
    reg  [1:0]       hv_en_q;
    reg  [1:0]       hv_pol_q;
    reg  [1:0]       hv_flag_q;
    reg  [1:0]       hv_flag_d;
    reg  [OC_W-1:0]  oc_en_q;
    reg  [OC_W-1:0]  oc_flag_q;
    reg  [OC_W-1:0]  oc_flag_d;
    reg  [1:0]       route_q;
    reg              ack_q;
    reg  [31:0]      rdata_d;

    wire [PIN_W-1:0] impl = PIN_IMPL;
    wire [1:0]       dien = hv_cfg_q[`HVIP_CFG_DIEN_LSB +: 2];
    wire [1:0]       aen  = hv_cfg_q[`HVIP_CFG_AEN_LSB +: 2];
    wire [1:0]       dir  = hv_cfg_q[`HVIP_CFG_DIR_LSB +: 2];
    wire [1:0]       ovr  = hv_cfg_q[`HVIP_CFG_OVR_LSB +: 2];

    // One wait cycle per access; the ack pulse releases the master.
    wire acc    = (AVS_READ | AVS_WRITE) & ~ack_q;
    wire wr_go  = AVS_WRITE & ack_q;
    wire lane0  = AVS_BYTEENABLE[0];
    wire lane1  = AVS_BYTEENABLE[1];
    wire [7:0]  wb0 = AVS_WRITEDATA[7:0];
    wire [7:0]  wb1 = AVS_WRITEDATA[15:8];

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;

    wire wr_pin_en  = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_PIN_EN);
    wire wr_pin_fl  = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_PIN_FLAG);
    wire wr_pin_pol = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_PIN_POL);
    wire wr_cfg     = wr_go & (AVS_ADDRESS == `HVIP_OFS_HV_CFG);
    wire wr_evt     = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_HV_EVT);
    wire wr_hv_fl   = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_HV_FLAG);
    wire wr_oc_en   = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_OC_EN);
    wire wr_oc_fl   = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_OC_FLAG);
    wire wr_route   = wr_go & lane0 & (AVS_ADDRESS == `HVIP_OFS_ROUTE);

    ////////////////////////////////////////////////////////////////////////////
    // High-voltage input mode selection.

    // Stop configuration needs both stop and the regulator in reduced mode.
    wire stop_cfg = STOP_MODE & REDUCED_PERF;

    reg  [1:0] buf_en;
    reg  [1:0] ana_on;
    reg  [1:0] evt_ok;
    integer    h;

    // Buffer, analog path and event permission per pin and mode.
    always @* begin
        buf_en = 2'h0;
        ana_on = 2'h0;
        evt_ok = 2'h0;
        for (h = 0; h < 2; h = h + 1) begin
            if (stop_cfg) begin
                buf_en[h] = dien[h];
                evt_ok[h] = dien[h];
            end else if (aen[h]) begin
                buf_en[h] = ovr[h] & ~dir[h];
                ana_on[h] = 1'b1;
            end else begin
                buf_en[h] = dien[h];
                evt_ok[h] = dien[h];
            end
        end
    end

    // A disabled buffer reads low, so no level or edge leaks through it.
    wire [1:0] hv_lvl = hv_s2_q & buf_en;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection and sticky flags.

    // The synchronised pad level is seen whatever the pin direction.
    wire [PIN_W-1:0] pin_rise = pin_s2_q & ~pin_prev_q;
    wire [PIN_W-1:0] pin_fall = ~pin_s2_q & pin_prev_q;
    wire [PIN_W-1:0] pin_edge = ((pin_rise & pin_pol_q) | (pin_fall & ~pin_pol_q)) & impl;
    wire [1:0] hv_rise = hv_lvl & ~hv_prev_q;
    wire [1:0] hv_fall = ~hv_lvl & hv_prev_q;
    wire [1:0] hv_edge = ((hv_rise & hv_pol_q) | (hv_fall & ~hv_pol_q)) & evt_ok;

    // Over-current counts only for a powered monitor at full drive on the
    // protected side; ground pins mirror the supply pin.
    reg  [OC_W-1:0] oc_side;
    integer         k;
    always @* begin
        oc_side = {OC_W{1'b0}};
        for (k = 0; k < OC_W; k = k + 1) begin
            if (k == 0) begin
                oc_side[k] = OC_OUT_HIGH[k];
            end else begin
                oc_side[k] = ~OC_OUT_HIGH[k];
            end
        end
    end
    wire [OC_W-1:0] oc_pwr = oc_en_q & {OC_W{~STOP_MODE}};
    wire [OC_W-1:0] oc_hit = oc_s2_q & oc_pwr & OC_FULL_DRIVE & oc_side;

    // Clear applies first and the new edge is ORed after, so set wins.
    always @* begin
        pin_flag_d = pin_flag_q;
        hv_flag_d  = hv_flag_q;
        oc_flag_d  = oc_flag_q;
        if (wr_pin_fl) begin
            pin_flag_d = pin_flag_q & ~wb0[PIN_W-1:0];
        end
        if (wr_hv_fl) begin
            hv_flag_d = hv_flag_q & ~wb0[1:0];
        end
        if (wr_oc_fl) begin
            oc_flag_d = oc_flag_q & ~wb0[OC_W-1:0];
        end
        pin_flag_d = (pin_flag_d | pin_edge) & impl;
        hv_flag_d  = hv_flag_d | hv_edge;
        oc_flag_d  = oc_flag_d | oc_hit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates.

    always @(posedge CLK) begin
        if (RST) begin
            pin_prev_q <= {PIN_W{1'b0}};
            hv_prev_q  <= `HVIP_RST_HV2;
            pin_en_q   <= {PIN_W{1'b0}};
            pin_flag_q <= {PIN_W{1'b0}};
            pin_pol_q  <= {PIN_W{1'b0}};
            hv_cfg_q   <= `HVIP_RST_CFG;
            hv_en_q    <= `HVIP_RST_HV2;
            hv_pol_q   <= `HVIP_RST_HV2;
            hv_flag_q  <= `HVIP_RST_HV2;
            oc_en_q    <= {OC_W{1'b0}};
            oc_flag_q  <= {OC_W{1'b0}};
            route_q    <= `HVIP_RST_ROUTE;
            ack_q      <= 1'b0;
        end else begin
            pin_prev_q <= pin_s2_q;
            hv_prev_q  <= hv_lvl;
            pin_flag_q <= pin_flag_d;
            hv_flag_q  <= hv_flag_d;
            oc_flag_q  <= oc_flag_d;
            ack_q      <= acc;
            if (wr_pin_en) begin
                pin_en_q <= wb0[PIN_W-1:0] & impl;
            end
            if (wr_pin_pol) begin
                pin_pol_q <= wb0[PIN_W-1:0] & impl;
            end
            if (wr_cfg & lane0) begin
                hv_cfg_q[7:0] <= wb0;
            end
            if (wr_cfg & lane1) begin
                hv_cfg_q[11:8] <= wb1[3:0];
            end
            if (wr_evt) begin
                hv_en_q  <= wb0[`HVIP_EVT_EN_LSB +: 2];
                hv_pol_q <= wb0[`HVIP_EVT_POL_LSB +: 2];
            end
            if (wr_oc_en) begin
                oc_en_q <= wb0[OC_W-1:0];
            end
            if (wr_route) begin
                route_q <= wb0[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data; unmapped addresses answer zero.

    always @* begin
        rdata_d = `HVIP_RST_DATA;
        case (AVS_ADDRESS)
            `HVIP_OFS_PIN_EN: begin
                rdata_d[PIN_W-1:0] = pin_en_q & impl;
            end
            `HVIP_OFS_PIN_FLAG: begin
                rdata_d[PIN_W-1:0] = pin_flag_q & impl;
            end
            `HVIP_OFS_PIN_POL: begin
                rdata_d[PIN_W-1:0] = pin_pol_q;
            end
            `HVIP_OFS_HV_CFG: begin
                rdata_d[11:0] = hv_cfg_q;
            end
            `HVIP_OFS_HV_EVT: begin
                rdata_d[`HVIP_EVT_EN_LSB +: 2]  = hv_en_q;
                rdata_d[`HVIP_EVT_POL_LSB +: 2] = hv_pol_q;
            end
            `HVIP_OFS_HV_FLAG: begin
                rdata_d[1:0] = hv_flag_q;
            end
            `HVIP_OFS_LEVELS: begin
                rdata_d[1:0] = hv_lvl;
                rdata_d[`HVIP_LVL_PIN_LSB +: PIN_W] = pin_s2_q & impl;
            end
            `HVIP_OFS_OC_EN: begin
                rdata_d[OC_W-1:0] = oc_en_q;
            end
            `HVIP_OFS_OC_FLAG: begin
                rdata_d[OC_W-1:0] = oc_flag_q;
            end
            `HVIP_OFS_ROUTE: begin
                rdata_d[1:0] = route_q;
            end
            default: begin
                rdata_d = `HVIP_RST_DATA;
            end
        endcase
    end

    // Read data is captured in the wait cycle and stands at the release edge.
    always @(posedge CLK) begin
        if (RST) begin
            AVS_READDATA <= `HVIP_RST_DATA;
        end else if (AVS_READ & ~ack_q) begin
            AVS_READDATA <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs toward the pads, the ADC and the timer.

    always @(posedge CLK) begin
        if (RST) begin
            PIN_IRQ        <= 1'b0;
            HV_IRQ         <= 1'b0;
            OC_IRQ         <= 1'b0;
            WAKEUP         <= 1'b0;
            HV_DIG_BUF_EN  <= `HVIP_RST_HV2;
            HV_ANA_EN      <= `HVIP_RST_HV2;
            HV_RATIO_SEL   <= `HVIP_RST_HV2;
            HV_DIRECT      <= `HVIP_RST_HV2;
            HV_IMP_BYPASS  <= `HVIP_RST_HV2;
            ADC_HV_CONNECT <= `HVIP_RST_HV2;
            OC_MON_PWR     <= {OC_W{1'b0}};
            OC_FORCE_LOW   <= {OC_W{1'b0}};
            TIM_IC3_OUT    <= 1'b0;
        end else begin
            PIN_IRQ <= |(pin_flag_q & pin_en_q);
            HV_IRQ  <= |(hv_flag_q & hv_en_q);
            OC_IRQ  <= |oc_flag_q;
            // Wakeup is meaningful only while the stop configuration holds.
            WAKEUP  <= stop_cfg & (|(hv_flag_q & hv_en_q) | |(pin_flag_q & pin_en_q));
            HV_DIG_BUF_EN <= buf_en;
            HV_ANA_EN     <= ana_on;
            HV_RATIO_SEL  <= hv_cfg_q[`HVIP_CFG_RATIO_LSB +: 2] & ana_on;
            HV_DIRECT     <= dir & ana_on;
            HV_IMP_BYPASS <= hv_cfg_q[`HVIP_CFG_BYP_LSB +: 2] & dir & ana_on;
            ADC_HV_CONNECT[0] <= ana_on[0] & (ADC_ADC_CHANNEL_SELECT == `HVIP_ADC_CH_HV0);
            ADC_HV_CONNECT[1] <= ana_on[1] & (ADC_ADC_CHANNEL_SELECT == `HVIP_ADC_CH_HV1);
            OC_MON_PWR    <= oc_pwr;
            // The driver stays forced low until software clears the flag.
            OC_FORCE_LOW  <= oc_flag_d;
            case (route_q)
                `HVIP_ROUTE_SERIAL0: begin
                    TIM_IC3_OUT <= rx0_s2_q;
                end
                `HVIP_ROUTE_SERIAL1: begin
                    TIM_IC3_OUT <= rx1_s2_q;
                end
                default: begin
                    TIM_IC3_OUT <= ic3_s2_q;
                end
            endcase
        end
    end

endmodule

/* File: tb/hvip_port_checker.sv */
`timescale 1ns/1ps
`include "hvip_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Pin-level checks on the port block; it sees the top ports only.
module hvip_port_checker #(
    parameter OC_W = 5
) (
    input wire            CLK,
    input wire            RST,
    input wire [5:0]      AVS_ADDRESS,
    input wire            AVS_READ,
    input wire            AVS_WRITE,
    input wire [31:0]     AVS_WRITEDATA,
    input wire [3:0]      AVS_BYTEENABLE,
    input wire            AVS_WAITREQUEST,
    input wire            STOP_MODE,
    input wire            REDUCED_PERF,
    input wire [OC_W-1:0] OC_FULL_DRIVE,
    input wire [OC_W-1:0] OC_OUT_HIGH,
    input wire [5:0]      ADC_ADC_CHANNEL_SELECT,
    input wire            PIN_IRQ,
    input wire            OC_IRQ,
    input wire            WAKEUP,
    input wire [1:0]      HV_DIG_BUF_EN,
    input wire [1:0]      HV_ANA_EN,
    input wire [1:0]      HV_DIRECT,
    input wire [1:0]      ADC_HV_CONNECT,
    input wire [OC_W-1:0] OC_MON_PWR,
    input wire [OC_W-1:0] OC_FORCE_LOW
);
    // One clock domain, so reset gating is stated once for every check.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////
    // Each request costs exactly one wait cycle.
    property p_bus_wait; $rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus wait not one cycle");
    // A zero enable write silences the pin interrupt two edges later.
    property p_irq_mask; AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `HVIP_OFS_PIN_EN
        && AVS_BYTEENABLE[0] && AVS_WRITEDATA[7:0] == 8'h00 |-> ##2 !PIN_IRQ; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked pin irq high");
    property p_reset_off; $fell(RST) |-> HV_DIG_BUF_EN == 2'h0 && HV_ANA_EN == 2'h0; endproperty
    a_reset_off: assert property (p_reset_off) else $error("hv path on after reset");
    property p_stop_oc; STOP_MODE |=> OC_MON_PWR == {OC_W{1'b0}}; endproperty
    a_stop_oc: assert property (p_stop_oc) else $error("monitor powered in stop");
    property p_oc_irq; |OC_FORCE_LOW |-> ##[0:1] OC_IRQ; endproperty
    a_oc_irq: assert property (p_oc_irq) else $error("forced low without irq");
    // The supply pin may only trip while sourcing at full drive in run mode.
    property p_oc_sup; $rose(OC_FORCE_LOW[0])
        |-> $past(OC_FULL_DRIVE[0] & OC_OUT_HIGH[0] & ~STOP_MODE); endproperty
    a_oc_sup: assert property (p_oc_sup) else $error("supply pin tripped wrongly");
    property p_dir_buf; HV_ANA_EN[0] && HV_DIRECT[0] |-> !HV_DIG_BUF_EN[0]; endproperty
    a_dir_buf: assert property (p_dir_buf) else $error("buffer on in direct analog");
    property p_adc_sel; ADC_HV_CONNECT[0] |-> $past(ADC_ADC_CHANNEL_SELECT) == `HVIP_ADC_CH_HV0; endproperty
    a_adc_sel: assert property (p_adc_sel) else $error("hv0 routed on wrong channel");
    property p_stop_ana; HV_ANA_EN != 2'h0 |-> !$past(STOP_MODE & REDUCED_PERF); endproperty
    a_stop_ana: assert property (p_stop_ana) else $error("analog on in stop");
    property p_wake; WAKEUP |-> $past(STOP_MODE & REDUCED_PERF); endproperty
    a_wake: assert property (p_wake) else $error("wakeup outside stop");
    c_trip: cover property (|OC_FORCE_LOW);
    c_wake: cover property (WAKEUP);
    c_adc: cover property (ADC_HV_CONNECT != 2'h0);
endmodule
bind hvip_port hvip_port_checker #(.OC_W(OC_W)) u_chk (.*);

/* File: tb/hvip_pins_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Pad side: moves levels just after an edge so the synchronisers see clean steps.
module hvip_pins_model (
    input  wire        clk,
    input  wire [17:0] want,
    output reg  [7:0]  pin,
    output reg  [1:0]  hv,
    output reg  [4:0]  oc,
    output reg         rx0,
    output reg         rx1,
    output reg         ic3
);
    // Receive lines idle high, as a serial line does.
    initial {ic3, rx1, rx0, oc, hv, pin} = 18'h18000;
    always @(posedge clk) begin
        {ic3, rx1, rx0, oc, hv, pin} <= want;
    end
endmodule

/* File: tb/hvip_port_test.sv */
`timescale 1ns/1ps
`include "hvip_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Random pad and register traffic from a fixed seed, so a failure replays.
module hvip_port_test;
    localparam [7:0] IMPL = 8'h7f;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [5:0]  adr = 6'h00;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wd = 32'h0;
    reg  [17:0] want = 18'h18000;
    reg         stop = 1'b0;
    reg         reduced = 1'b0;
    reg  [4:0]  high = 5'h01;
    reg  [4:0]  full = 5'h1f;
    reg  [5:0]  chsel = 6'h00;
    reg  [31:0] seed = 32'd78600;
    reg  [31:0] v, q;
    reg  [7:0]  e;
    reg  [1:0]  a, b;
    integer     err_count = 0;
    integer     num_checks = 0;
    integer     i, k;
    wire [31:0] rdat;
    wire [7:0]  pin;
    wire [4:0]  oc, pwr, low;
    wire [1:0]  hv, buf_en, ana, ratio, dir, byp, adc;
    wire        wreq, rx0, rx1, ic3, pin_irq, hv_irq, oc_irq, wake, tim_out;
    hvip_port #(.PIN_IMPL(IMPL)) u_dut (
        .CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .PIN_IN(pin), .HV_PIN_IN(hv), .STOP_MODE(stop),
        .REDUCED_PERF(reduced), .OC_DETECT(oc), .OC_FULL_DRIVE(full), .OC_OUT_HIGH(high),
        .ADC_ADC_CHANNEL_SELECT(chsel), .RXD0_IN(rx0), .RXD1_IN(rx1), .TIM_IC3_PIN(ic3),
        .PIN_IRQ(pin_irq), .HV_IRQ(hv_irq), .OC_IRQ(oc_irq), .WAKEUP(wake),
        .HV_DIG_BUF_EN(buf_en), .HV_ANA_EN(ana), .HV_RATIO_SEL(ratio), .HV_DIRECT(dir),
        .HV_IMP_BYPASS(byp), .ADC_HV_CONNECT(adc), .OC_MON_PWR(pwr), .OC_FORCE_LOW(low),
        .TIM_IC3_OUT(tim_out)
    );
    hvip_pins_model u_pads (
        .clk(clk), .want(want), .pin(pin), .hv(hv), .oc(oc), .rx0(rx0), .rx1(rx1), .ic3(ic3)
    );
    // Free-running 40 MHz clock.
    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Xorshift step; a zero state would stick, the fixed seed never gets there.
    function [31:0] rnd(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            rnd = x ^ (x << 5);
        end
    endfunction
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One bus transfer; the request holds until waitrequest is seen low.
    task bus(input w, input [5:0] ad, input [31:0] d);
        begin
            @(posedge clk);
            adr <= ad;
            wd <= d;
            wr <= w;
            rd <= ~w;
            @(posedge clk);
            while (wreq !== 1'b0) @(posedge clk);
            q = rdat;
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task rchk(input [63:0] nm, input [5:0] ad, input [31:0] exp);
        begin
            bus(1'b0, ad, 32'h0);
            chk(nm, q, exp);
        end
    endtask
    // Sample away from the edge so results never race the design's updates.
    task settle(input integer n);
        begin
            repeat (n) @(posedge clk);
            @(negedge clk);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    // Watchdog, far beyond the several hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        err_count = err_count + 1;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Every register starts clear; word 0x28 is unmapped.
        for (i = 0; i < 11; i = i + 1) begin
            rchk("reset", {i[3:0], 2'b00}, 32'h0);
        end
        bus(1'b1, 6'h28, 32'hffff_ffff);
        rchk("unmap", 6'h28, 32'h0);
        bus(1'b1, `HVIP_OFS_PIN_EN, 32'hff);
        rchk("impl", `HVIP_OFS_PIN_EN, {24'h0, IMPL});
        // Random pin steps; every fourth pass sits in the stop configuration to see wakeup.
        for (k = 0; k < 8; k = k + 1) begin
            seed = rnd(seed);
            v = seed;
            @(posedge clk);
            want[7:0] <= v[7:0];
            stop <= k[0];
            reduced <= k[1];
            bus(1'b1, `HVIP_OFS_PIN_POL, {24'h0, v[23:16]});
            bus(1'b1, `HVIP_OFS_PIN_EN, {24'h0, v[31:24]});
            bus(1'b1, `HVIP_OFS_PIN_FLAG, 32'hff);
            @(posedge clk);
            want[7:0] <= v[15:8];
            settle(6);
            e = (v[7:0] ^ v[15:8]) & ~(v[23:16] ^ v[15:8]) & IMPL;
            rchk("pflag", `HVIP_OFS_PIN_FLAG, {24'h0, e});
            chk("pirq", pin_irq, |(e & v[31:24]));
            chk("wake", wake, &k[1:0] & |(e & v[31:24]));
            bus(1'b1, `HVIP_OFS_PIN_FLAG, {24'h0, v[7:0]});
            rchk("w1c", `HVIP_OFS_PIN_FLAG, {24'h0, e & ~v[7:0]});
        end
        // An edge landing on the clearing write must keep its flag set.
        bus(1'b1, `HVIP_OFS_PIN_POL, 32'hff);
        bus(1'b1, `HVIP_OFS_PIN_FLAG, 32'hff);
        @(posedge clk);
        e = ~want[7:0] & IMPL;
        want[7:0] <= ~want[7:0];
        @(posedge clk);
        bus(1'b1, `HVIP_OFS_PIN_FLAG, 32'hff);
        rchk("setwin", `HVIP_OFS_PIN_FLAG, {24'h0, e});
        bus(1'b1, `HVIP_OFS_PIN_EN, 32'h0);
        settle(2);
        chk("mask", pin_irq, 1'b0);
        // Random high-voltage settings against the run and stop table.
        for (k = 0; k < 16; k = k + 1) begin
            seed = rnd(seed);
            v = seed;
            @(posedge clk);
            stop <= v[12];
            reduced <= v[13];
            chsel <= v[14] ? `HVIP_ADC_CH_HV1 : `HVIP_ADC_CH_HV0;
            bus(1'b1, `HVIP_OFS_HV_CFG, {20'h0, v[11:0]});
            settle(2);
            a = (v[12] & v[13]) ? 2'b00 : v[3:2];
            b = (v[1:0] & ~v[3:2]) | (v[3:2] & v[11:10] & ~v[7:6]);
            chk("buf", buf_en, (v[12] & v[13]) ? v[1:0] : b);
            chk("ana", ana, a);
            chk("anaout", {ratio, dir, byp}, {a & v[5:4], a & v[7:6], a & v[7:6] & v[9:8]});
            chk("adc", adc, a & (v[14] ? 2'b10 : 2'b01));
        end
        // Digital mode flags both edge kinds; analog mode then blocks them.
        @(posedge clk);
        stop <= 1'b0;
        reduced <= 1'b0;
        want[9:0] <= 10'h200;
        bus(1'b1, `HVIP_OFS_HV_CFG, 32'h3);
        bus(1'b1, `HVIP_OFS_HV_EVT, 32'h7);
        bus(1'b1, `HVIP_OFS_HV_FLAG, 32'h3);
        @(posedge clk);
        want[9:8] <= 2'b01;
        settle(6);
        rchk("hflag", `HVIP_OFS_HV_FLAG, 32'h3);
        chk("hirq", hv_irq, 1'b1);
        rchk("hlvl", `HVIP_OFS_LEVELS, 32'h1);
        bus(1'b1, `HVIP_OFS_HV_CFG, 32'hc);
        bus(1'b1, `HVIP_OFS_HV_FLAG, 32'h3);
        @(posedge clk);
        want[9:8] <= 2'b10;
        settle(6);
        rchk("hana", `HVIP_OFS_HV_FLAG, 32'h0);
        rchk("hlvl0", `HVIP_OFS_LEVELS, 32'h0);
        // Over-current trips latch; wrong drive side and stop leave drivers alone.
        seed = rnd(seed);
        e = {3'h0, seed[4:0] | 5'h03};
        bus(1'b1, `HVIP_OFS_OC_EN, {24'h0, e});
        settle(2);
        chk("ocpwr", pwr, e[4:0]);
        @(posedge clk);
        want[14:10] <= 5'h1f;
        settle(6);
        chk("force", low, e[4:0]);
        chk("ocirq", oc_irq, 1'b1);
        rchk("ocflag", `HVIP_OFS_OC_FLAG, {24'h0, e});
        @(posedge clk);
        want[14:10] <= 5'h00;
        high <= 5'h1e;
        settle(4);
        bus(1'b1, `HVIP_OFS_OC_FLAG, 32'h1f);
        rchk("occlr", `HVIP_OFS_OC_FLAG, 32'h0);
        @(posedge clk);
        want[14:10] <= 5'h1f;
        settle(6);
        chk("noprot", low, 5'h00);
        @(posedge clk);
        high <= 5'h01;
        stop <= 1'b1;
        settle(6);
        chk("stop", {pwr, low}, 10'h0);
        @(posedge clk);
        want[14:10] <= 5'h00;
        settle(5);
        @(posedge clk);
        stop <= 1'b0;
        // Code 0 selects serial 0, code 2 serial 1, and codes 1 and 3 both the timer pin.
        for (k = 0; k < 4; k = k + 1) begin
            bus(1'b1, `HVIP_OFS_ROUTE, k);
            for (i = 0; i < 3; i = i + 1) begin
                seed = rnd(seed);
                @(posedge clk);
                want[17:15] <= seed[2:0];
                settle(5);
                chk("route", tim_out, k == 0 ? seed[0] : k == 2 ? seed[1] : seed[2]);
            end
        end
        stop_test;
    end
endmodule
